// file: design/sync_serial_slave_port.sv
// Synchronous slave serial port: transmit and receive on an external shift clock.
// Assumes an APB master on pclk; shift clock and data pin come asynchronously.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sync_slave_defs.svh"

// Behaviour
// - Slave behaves as master except in sleep and idle states.
// - First of two written words moves at once into the shift register.
// - Second word waits in holding register; transmit empty flag stays clear.
// - After first word, second moves into shift register, then flag sets.
// - Transmit empty flag with its enable raises a wake-up request.
// - With transmitter enabled, a holding write starts a transmission on external clocks.
// - Single receive enable is ignored; continuous receive alone governs reception.
// - Reception continues during low-power states when continuous receive is set.
// - A fully received word moves from shift register to holding register.
// - Receive complete flag sets on completion; with its enable it wakes the chip.
// - Receive ninth-bit select adds a ninth data bit per word.
// - Receive status shows ninth bit and overrun error; the framing error bit always reads zero.
// - Reading receive holding returns the low eight data bits.
// - Clearing continuous receive clears pending receive errors.
// - Transmit status bit order: clock source down to ninth data bit.
// - Receive data is sampled on the falling shift clock edge.
// - Transmit empty flag clears only by writing the holding register.
// - Shift-empty status is read-only, set while the shift register is idle.
module sync_serial_slave_port (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link; the data pin is two-way, enable low while driving.
  input  wire logic        shift_clock_pin,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_oe_n,
  // Wake-up request towards the interrupt controller.
  output logic             wake_request
);

  sync_slave_pkg::state_s s_q;
  sync_slave_pkg::state_s s_d;

  logic ck_fall;
  logic slave_on;
  logic rx_on;
  logic tx_on;
  logic wr;
  logic rd;
  logic [8:0] word_in;

  // Only the second and third sync stages feed edge detection.
  assign ck_fall  = ~s_q.ck_sync[1] & s_q.ck_sync[2];
  // The device never drives the shift clock pin, so it has no output here.
  assign slave_on = s_q.rx_ctrl[`BIT_PORT_EN] & s_q.tx_ctrl[`BIT_SYNC_MODE]
                    & ~s_q.tx_ctrl[`BIT_CLK_SRC];
  // Half duplex as in master mode; single receive is a don't-care.
  assign rx_on    = slave_on & s_q.rx_ctrl[`BIT_CONT_RX];
  assign tx_on    = slave_on & s_q.tx_ctrl[`BIT_TX_EN] & ~rx_on;
  assign wr       = psel & penable & pwrite & ~s_q.pready;
  assign rd       = psel & penable & ~pwrite & ~s_q.pready;
  assign word_in  = {s_q.dt_sync[1], s_q.rx_shift[8:1]};

  always_comb begin
    s_d = s_q;
    s_d.ck_sync = {s_q.ck_sync[1:0], shift_clock_pin};
    s_d.dt_sync = {s_q.dt_sync[0], serial_data_in};
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;

    // Transmit: load from holding when idle, shift on falling clock edges.
    case (s_q.tx_state)
      sync_slave_pkg::TX_IDLE: begin
        s_d.data_oe_n = 1'b1;
        if (tx_on && s_q.tx_hold_full) begin
          s_d.tx_shift     = s_q.tx_hold;
          s_d.tx_count     = s_q.tx_ctrl[`BIT_TX9_SEL] ? 4'h9 : 4'h8;
          s_d.tx_hold_full = 1'b0;
          s_d.tx_flag      = 1'b1;
          s_d.tx_state     = sync_slave_pkg::TX_SHIFT;
          s_d.data_out     = s_q.tx_hold[0];
          s_d.data_oe_n    = 1'b0;
        end
      end
      sync_slave_pkg::TX_SHIFT: begin
        if (!tx_on) begin
          s_d.tx_state  = sync_slave_pkg::TX_IDLE;
          s_d.data_oe_n = 1'b1;
        end else if (ck_fall) begin
          s_d.tx_shift = {1'b0, s_q.tx_shift[8:1]};
          s_d.tx_count = s_q.tx_count - 4'h1;
          s_d.data_out = s_q.tx_shift[1];
          if (s_q.tx_count == 4'h1) begin
            if (s_q.tx_hold_full) begin
              // Second word follows straight on; its flag sets now.
              s_d.tx_shift     = s_q.tx_hold;
              s_d.tx_count     = s_q.tx_ctrl[`BIT_TX9_SEL] ? 4'h9 : 4'h8;
              s_d.tx_hold_full = 1'b0;
              s_d.tx_flag      = 1'b1;
              s_d.data_out     = s_q.tx_hold[0];
            end else begin
              s_d.tx_state  = sync_slave_pkg::TX_IDLE;
              s_d.data_oe_n = 1'b1;
            end
          end
        end
      end
      default: s_d.tx_state = sync_slave_pkg::TX_IDLE;
    endcase

    // Receive: sample data on the falling shift clock edge.
    if (!rx_on) begin
      s_d.rx_count = 4'h0;
      s_d.overrun  = 1'b0;
    end else if (ck_fall) begin
      s_d.rx_shift = word_in;
      s_d.rx_count = s_q.rx_count + 4'h1;
      if (s_q.rx_count == (s_q.rx_ctrl[`BIT_RX9_SEL] ? 4'h8 : 4'h7)) begin
        s_d.rx_count = 4'h0;
        if (s_q.rx_flag) begin
          s_d.overrun = 1'b1;
        end else begin
          s_d.rx_hold = s_q.rx_ctrl[`BIT_RX9_SEL] ? word_in : {1'b0, word_in[8:1]};
          s_d.rx_flag = 1'b1;
        end
      end
    end

    // APB access; every access answers with one wait state, in the second access cycle.
    if (wr) begin
      s_d.pready = 1'b1;
      case (paddr)
        `OFS_ENABLES:    s_d.enables    = pwdata[7:0] & `ENABLES_MASK;
        `OFS_PRIORITIES: s_d.priorities = pwdata[7:0] & `ENABLES_MASK;
        `OFS_RX_STATUS:  s_d.rx_ctrl    = pwdata[7:0] & `RX_CTRL_MASK;
        `OFS_TX_STATUS: begin
          s_d.tx_ctrl = pwdata[7:0] & `TX_CTRL_MASK;
          s_d.tx_hold[8] = pwdata[`BIT_TX9_VAL];
        end
        `OFS_RATE_DIV:   s_d.rate_div   = pwdata[7:0];
        `OFS_TX_HOLD: begin
          // Overwrites a held word; software should wait for the flag.
          s_d.tx_hold      = {s_q.tx_ctrl[`BIT_TX9_VAL], pwdata[7:0]};
          s_d.tx_hold_full = 1'b1;
          s_d.tx_flag      = 1'b0;
        end
        `OFS_FLAGS: ;
        `OFS_RX_HOLD: ;
        default: s_d.pslverr = 1'b1;
      endcase
    end else if (rd) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      case (paddr)
        `OFS_FLAGS: begin
          s_d.prdata[`BIT_RX_FLAG] = s_q.rx_flag;
          s_d.prdata[`BIT_TX_FLAG] = s_q.tx_flag;
        end
        `OFS_ENABLES:    s_d.prdata[7:0] = s_q.enables;
        `OFS_PRIORITIES: s_d.prdata[7:0] = s_q.priorities;
        `OFS_RX_STATUS: begin
          s_d.prdata[7:0]            = s_q.rx_ctrl;
          s_d.prdata[`BIT_OVERRUN]   = s_q.overrun;
          s_d.prdata[`BIT_RX9_VAL]   = s_q.rx_hold[8];
        end
        `OFS_TX_STATUS: begin
          s_d.prdata[7:0] = s_q.tx_ctrl;
          s_d.prdata[`BIT_SR_EMPTY] = (s_q.tx_state == sync_slave_pkg::TX_IDLE);
          s_d.prdata[`BIT_TX9_VAL]  = s_q.tx_hold[8];
        end
        `OFS_RATE_DIV:   s_d.prdata[7:0] = s_q.rate_div;
        `OFS_TX_HOLD:    s_d.prdata[7:0] = s_q.tx_hold[7:0];
        `OFS_RX_HOLD: begin
          s_d.prdata[7:0] = s_q.rx_hold[7:0];
          // A new word landing this cycle keeps the flag set.
          if (!(s_d.rx_flag && !s_q.rx_flag)) begin
            s_d.rx_flag = 1'b0;
          end
        end
        default: s_d.pslverr = 1'b1;
      endcase
    end

    s_d.wake = (s_d.tx_flag & s_d.enables[`BIT_TX_FLAG])
               | (s_d.rx_flag & s_d.enables[`BIT_RX_FLAG]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q           <= '0;
      s_q.data_oe_n <= 1'b1;
      s_q.tx_state  <= sync_slave_pkg::TX_IDLE;
      s_q.tx_flag   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata           = s_q.prdata;
  assign pready           = s_q.pready;
  assign pslverr          = s_q.pslverr;
  assign serial_data_out  = s_q.data_out;
  assign serial_data_oe_n = s_q.data_oe_n;
  assign wake_request     = s_q.wake;

endmodule
`default_nettype wire

// file: pkg/sync_slave_defs.svh
// Register offsets, field positions and reset values of the synchronous slave port.
// Assumes an APB slave with 32-bit data and one aligned word per register.
`ifndef SYNC_SLAVE_DEFS_SVH
`define SYNC_SLAVE_DEFS_SVH

`define OFS_FLAGS      12'h000
`define OFS_ENABLES    12'h004
`define OFS_PRIORITIES 12'h008
`define OFS_RX_STATUS  12'h00C
`define OFS_TX_HOLD    12'h010
`define OFS_TX_STATUS  12'h014
`define OFS_RATE_DIV   12'h018
`define OFS_RX_HOLD    12'h01C

`define BIT_RX_FLAG    5
`define BIT_TX_FLAG    4

`define BIT_PORT_EN    7
`define BIT_RX9_SEL    6
`define BIT_SINGLE_RX  5
`define BIT_CONT_RX    4
`define BIT_ADDR_EN    3
`define BIT_FRAME_ERR  2
`define BIT_OVERRUN    1
`define BIT_RX9_VAL    0

`define BIT_CLK_SRC    7
`define BIT_TX9_SEL    6
`define BIT_TX_EN      5
`define BIT_SYNC_MODE  4
`define BIT_HIGH_SPEED 2
`define BIT_SR_EMPTY   1
`define BIT_TX9_VAL    0

`define ENABLES_MASK   8'h76
`define RX_CTRL_MASK   8'hF8
`define TX_CTRL_MASK   8'hF5
`define RESET_BYTE     8'h00

`endif

// file: pkg/sync_slave_pkg.sv
// Types shared by the synchronous slave port.
// Assumes the companion defs header for numbers.
package sync_slave_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_e;

  typedef struct packed {
    logic [2:0]  ck_sync;
    logic [1:0]  dt_sync;
    logic [7:0]  enables;
    logic [7:0]  priorities;
    logic [7:0]  rx_ctrl;
    logic [7:0]  tx_ctrl;
    logic [7:0]  rate_div;
    logic [8:0]  tx_hold;
    logic        tx_hold_full;
    logic        tx_flag;
    tx_state_e   tx_state;
    logic [8:0]  tx_shift;
    logic [3:0]  tx_count;
    logic        data_out;
    logic        data_oe_n;
    logic [8:0]  rx_shift;
    logic [3:0]  rx_count;
    logic [8:0]  rx_hold;
    logic        rx_flag;
    logic        overrun;
    logic        wake;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } state_s;
endpackage

// file: tb/sync_serial_slave_port_properties.sv
// Checker of the slave port's APB answers and transmit pin timing.
// Assumes binding onto the port's top module; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sync_slave_checker (
  // Ports watched.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        shift_clock_pin,
  input wire logic        serial_data_out,
  input wire logic        serial_data_oe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_access_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  ready_cause_a: assert property (pready |-> $past(psel && penable) && psel && penable)
    else $error("pready outside access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  err_unmapped_a: assert property (pready && (paddr > 12'h01C || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("no error on unmapped");
  mapped_ok_a: assert property (pready && paddr <= 12'h01C && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on mapped");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  tx_data_hold_a: assert property ((shift_clock_pin && !serial_data_oe_n)[*5] |-> $stable(serial_data_out))
    else $error("data moved without clock");
endmodule
bind sync_serial_slave_port sync_slave_checker i_checker (.*);
`default_nettype wire

// file: tb/shift_master_model.sv
// External master of the link: makes the shift clock, drives or samples data.
// Assumes the bench resolves the shared data wire and returns it on line.
`timescale 1ns/1ps
`default_nettype none
module shift_master_model (
  // Link side.
  output logic     shift_clock_pin,
  output logic     m_data,
  output logic     m_drive,
  input wire logic line
);
  initial begin
    shift_clock_pin = 1'b1;
    m_data = 1'b0;
    m_drive = 1'b0;
  end
  // The clock idles high, so every bit costs exactly one falling edge.
  task automatic xfer(input logic [8:0] d, input int n, input logic drv, output logic [8:0] q);
    q = 9'h000;
    // Start off the bench clock's edges, so no link pin moves at a sampling edge.
    #7;
    m_drive = drv;
    for (int i = 0; i < n; i++) begin
      m_data = d[i];
      #100;
      q[i] = line;
      shift_clock_pin = 1'b0;
      #100;
      shift_clock_pin = 1'b1;
    end
    m_drive = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/sync_serial_slave_port_tb.sv
// Testbench of the slave port: APB master, scenarios and closing report.
// Assumes the master model on the link and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "sync_slave_defs.svh"
module sync_serial_slave_port_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        ck, m_data, m_drive, dout, oe_n, wake;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0]  q;
  int          fail_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  // A released line shows the inverse of the master model's m_data level.
  wire logic   line = !oe_n ? dout : (m_drive ? m_data : !m_data);
  sync_serial_slave_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .shift_clock_pin(ck), .serial_data_in(line),
    .serial_data_out(dout), .serial_data_oe_n(oe_n), .wake_request(wake));
  shift_master_model i_master (.shift_clock_pin(ck), .m_data(m_data), .m_drive(m_drive),
    .line(line));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      fail_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input string s, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(s, e, rd);
  endtask
  task automatic t_reset();
    rchk("txstat", `OFS_TX_STATUS, 32'h02);
    wr(`OFS_FLAGS, 32'h00);
    rchk("flags", `OFS_FLAGS, 32'h10);
    apb(1'b0, 12'h020, 32'h00000000);
    chk("unmapped", 32'h1, {31'h0, err});
    wr(`OFS_TX_STATUS, 32'hDD);
    rchk("txorder", `OFS_TX_STATUS, 32'hD7);
    wr(`OFS_PRIORITIES, 32'hFF);
    rchk("prio", `OFS_PRIORITIES, 32'h76);
    wr(`OFS_RATE_DIV, 32'hA5);
    rchk("divisor", `OFS_RATE_DIV, 32'hA5);
    $display("reset test done");
  endtask
  task automatic t_abort();
    wr(`OFS_TX_STATUS, 32'h30);
    wr(`OFS_RX_STATUS, 32'h80);
    wr(`OFS_TX_HOLD, 32'h55);
    rchk("busy", `OFS_TX_STATUS, 32'h30);
    chk("drive", 32'h0, {31'h0, oe_n});
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("release", 32'h1, {31'h0, oe_n});
    rchk("idle", `OFS_TX_STATUS, 32'h02);
    rchk("rstflag", `OFS_FLAGS, 32'h10);
    $display("abort test done");
  endtask
  task automatic t_tx();
    wr(`OFS_RX_STATUS, 32'h80);
    wr(`OFS_TX_STATUS, 32'h30);
    wr(`OFS_ENABLES, 32'h10);
    wr(`OFS_TX_HOLD, 32'hA5);
    wr(`OFS_TX_HOLD, 32'h3C);
    rchk("busyflag", `OFS_FLAGS, 32'h00);
    chk("wake0", 32'h0, {31'h0, wake});
    i_master.xfer(9'h000, 8, 1'b0, q);
    chk("word1", 32'hA5, {23'h0, q});
    rchk("loadflag", `OFS_FLAGS, 32'h10);
    chk("wake1", 32'h1, {31'h0, wake});
    i_master.xfer(9'h000, 8, 1'b0, q);
    chk("word2", 32'h3C, {23'h0, q});
    rchk("empty", `OFS_TX_STATUS, 32'h32);
    wr(`OFS_TX_STATUS, 32'h71);
    wr(`OFS_TX_HOLD, 32'h5A);
    i_master.xfer(9'h000, 9, 1'b0, q);
    chk("word9", 32'h15A, {23'h0, q});
    $display("transmit test done");
  endtask
  task automatic t_rx();
    wr(`OFS_TX_STATUS, 32'h10);
    wr(`OFS_ENABLES, 32'h20);
    wr(`OFS_RX_STATUS, 32'hA0);
    i_master.xfer(9'h096, 8, 1'b1, q);
    rchk("single", `OFS_FLAGS, 32'h10);
    wr(`OFS_RX_STATUS, 32'hB0);
    i_master.xfer(9'h096, 8, 1'b1, q);
    chk("wakerx", 32'h1, {31'h0, wake});
    rchk("rxflag", `OFS_FLAGS, 32'h30);
    rchk("rxdata", `OFS_RX_HOLD, 32'h96);
    wr(`OFS_RX_STATUS, 32'hD0);
    i_master.xfer(9'h1C3, 9, 1'b1, q);
    rchk("ninth", `OFS_RX_STATUS, 32'hD1);
    rchk("rx9data", `OFS_RX_HOLD, 32'hC3);
    i_master.xfer(9'h011, 9, 1'b1, q);
    i_master.xfer(9'h122, 9, 1'b1, q);
    rchk("overrun", `OFS_RX_STATUS, 32'hD2);
    wr(`OFS_RX_STATUS, 32'hC0);
    rchk("errclr", `OFS_RX_STATUS, 32'hC0);
    rchk("kept", `OFS_RX_HOLD, 32'h11);
    $display("receive test done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_abort();
    finish_test();
  end
endmodule
`default_nettype wire
